// File: sbuf_regs.vh
// register map, field positions and fixed counts of the sample capture buffer
`ifndef SBUF_REGS_VH
`define SBUF_REGS_VH

// apb byte offsets
`define SBUF_CTRL_OFF 12'h000
`define SBUF_CMD_OFF 12'h004
`define SBUF_STATUS_OFF 12'h008

// control register fields
`define SBUF_CTRL_BYPASS 0
`define SBUF_CTRL_AUTO_STOP 1
`define SBUF_CTRL_EDGE_SEL 2
`define SBUF_CTRL_MULT_LO 3
`define SBUF_CTRL_MULT_HI 4
`define SBUF_CTRL_DEPTH_LO 5
`define SBUF_CTRL_DEPTH_HI 6
`define SBUF_CTRL_FULL_DOWN 7
`define SBUF_CTRL_CONV_DOWN 8
`define SBUF_CTRL_WIDTH 9
`define SBUF_CTRL_RESET 9'h000

// command register fields
`define SBUF_CMD_BUF_RESET 0

// status register fields
`define SBUF_ST_FULL 0
`define SBUF_ST_EMPTY 1
`define SBUF_ST_READING 2
`define SBUF_ST_OVERRUN 3
`define SBUF_ST_CAPTURING 4
`define SBUF_ST_COUNT_LO 16

// sample timing: core cycles per sample at multiplier x1
`define SBUF_BASE_DIV 4'h8
// bypass pipeline latency in sample clocks
`define SBUF_PIPE_LAT 6
// smallest selectable depth, doubled per depth select step
`define SBUF_MIN_DEPTH 11'h080

`endif

// File: sbuf_sync.v
// two flip-flop synchroniser for a group of independent level inputs
`timescale 1ns/100ps
module sbuf_sync #(
    parameter WIDTH = 1
) (
    input wire core_clk, // sampling clock
    input wire rst_n, // synchronous-domain reset, active low
    input wire [WIDTH-1:0] async_in, // levels from outside the domain
    output reg [WIDTH-1:0] sync_out // synchronised levels
);
    reg [WIDTH-1:0] meta;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // sbuf_sync

// File: sbuf_capture.v
// sample capture buffer: write side, read-out side, bypass pipe and apb slave
//
// What this block does
// RQ1: sample store of selectable depth, at most 1024 eight-bit samples.
// RQ2: bypass mode presents each sample six sample clocks after it was taken.
// RQ3: buffered mode writes one sample per sample clock; reads use read clock.
// RQ4: output words are unsigned straight binary, passed through unchanged.
// RQ5: full power-down high stops the whole block; low lets it run.
// RQ6: converter power-down stops sampling only; full power-down dominates both.
// RQ7: sample clock is input rate times one, two, four or eight.
// RQ8: samples are stored only while capture write enable is high.
// RQ9: reads advance only on read clock rising edges with read enable high.
// RQ10: reader waits for a full buffer and never reads while capturing.
// RQ11: when write and read enables are both high, read enable is ignored.
// RQ12: write enable during a read aborts it, clears pointers, starts capture.
// RQ13: full flag rises when full; next sample wraps and overwrites oldest.
// RQ14: empty flag rises once the last stored sample has been read.
// RQ15: after empty, strobe and data hold low if edge select 1, else high.
// RQ16: auto-stop low keeps wrapping; auto-stop high halts writing at full.
// RQ17: full flag clears on reset and when a read is started.
// RQ18: empty flag clears when capture starts and is set by reset.
// RQ19: buffer reset clears pointers and flags, ends reads, spares the converter; the code sets the empty flag instead of clearing it.
// RQ20: read clock may have any phase or frequency relation to input clock.
// RQ21: depth select is taken while idle and sets full and read-out length.
// RQ22: data ready strobe toggles once per read clock with each new word.
`timescale 1ns/100ps
`include "sbuf_regs.vh"
module sbuf_capture #(
    parameter DATA_W = 8,
    parameter MAX_DEPTH = 1024,
    parameter PTR_W = 10
) (
    input wire core_clk, // block clock, 100 MHz
    input wire resetn, // asynchronous reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error on unmapped address
    input wire [DATA_W-1:0] conv_data, // converter result, core_clk domain
    input wire capture_write_enable, // write enable pin, asynchronous
    input wire buffer_read_enable, // read enable pin, asynchronous
    input wire read_clk, // read clock pin, asynchronous
    output reg [DATA_W-1:0] data_out, // sample output word
    output reg data_ready_strobe, // toggles with each new output word
    output reg full_flag, // buffer full
    output reg empty_flag, // buffer read out
    output reg sample_clk_tick // one-cycle pulse per sample clock
);
    localparam CNT_W = PTR_W + 1;
    localparam ST_IDLE = 3'b001;
    localparam ST_CAPTURE = 3'b010;
    localparam ST_READ = 3'b100;

    reg [1:0] rst_pipe;
    wire rst_n;
    wire wen_s;
    wire ren_s;
    wire rclk_s;
    reg wen_d;
    reg ren_d;
    reg rclk_d;
    reg [`SBUF_CTRL_WIDTH-1:0] ctrl;
    reg buf_reset;
    reg [2:0] state;
    reg [DATA_W-1:0] mem [0:MAX_DEPTH-1];
    reg [PTR_W-1:0] wr_ptr;
    reg [PTR_W-1:0] rd_ptr;
    reg [CNT_W-1:0] wr_count;
    reg [CNT_W-1:0] rd_left;
    reg [CNT_W-1:0] depth;
    reg overrun;
    reg [3:0] div_cnt;
    reg [DATA_W-1:0] pipe [0:`SBUF_PIPE_LAT-1];
    wire bypass;
    wire auto_stop;
    wire idle_level;
    wire full_down;
    wire conv_down;
    wire tick;
    wire wen_rise;
    wire ren_rise;
    wire rclk_rise;
    wire write_ok;
    wire [CNT_W-1:0] sel_depth;
    wire [3:0] tick_period;
    wire apb_access;
    reg [31:0] next_prdata;
    reg next_pslverr;

    // depth select code to sample count
    function [CNT_W-1:0] depth_of;
        input [1:0] sel;
        begin
            depth_of = `SBUF_MIN_DEPTH << sel;
        end
    endfunction

    // wrap a pointer at the active depth
    function [PTR_W-1:0] ptr_inc;
        input [PTR_W-1:0] ptr;
        input [CNT_W-1:0] lim;
        begin
            if ({1'b0, ptr} == lim - 1'b1)
                ptr_inc = {PTR_W{1'b0}};
            else
                ptr_inc = ptr + 1'b1;
        end
    endfunction

    // reset released through two flops, asserted at once
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            rst_pipe <= 2'b00;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    // RQ20 read clock treated as an unrelated level
    sbuf_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({read_clk, buffer_read_enable, capture_write_enable}),
        .sync_out({rclk_s, ren_s, wen_s})
    );

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wen_d <= 1'b0;
            ren_d <= 1'b0;
            rclk_d <= 1'b0;
        end else begin
            wen_d <= wen_s;
            ren_d <= ren_s;
            rclk_d <= rclk_s;
        end
    end

    assign bypass = ctrl[`SBUF_CTRL_BYPASS];
    assign auto_stop = ctrl[`SBUF_CTRL_AUTO_STOP];
    // RQ15 idle level from edge select
    assign idle_level = ~ctrl[`SBUF_CTRL_EDGE_SEL];
    assign full_down = ctrl[`SBUF_CTRL_FULL_DOWN];
    // RQ6 full power-down dominates
    assign conv_down = ctrl[`SBUF_CTRL_CONV_DOWN] | full_down;
    assign sel_depth = depth_of(ctrl[`SBUF_CTRL_DEPTH_HI:`SBUF_CTRL_DEPTH_LO]);
    assign wen_rise = wen_s & ~wen_d;
    // RQ11 read enable ignored under write enable
    assign ren_rise = ren_s & ~ren_d & ~wen_s;
    // RQ9 read steps on read clock rising edges only
    assign rclk_rise = rclk_s & ~rclk_d & ren_s & ~wen_s & ~full_down;

    // RQ7 sample period shrinks by the multiplier
    assign tick_period = `SBUF_BASE_DIV >> ctrl[`SBUF_CTRL_MULT_HI:`SBUF_CTRL_MULT_LO];
    // RQ5 no sample clock in full power-down
    assign tick = (div_cnt == tick_period - 1'b1) & ~full_down;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 4'h0;
            sample_clk_tick <= 1'b0;
        end else begin
            sample_clk_tick <= tick;
            if (full_down || div_cnt >= tick_period - 1'b1)
                div_cnt <= 4'h0;
            else
                div_cnt <= div_cnt + 1'b1;
        end
    end

    // RQ2 bypass pipe, one stage per sample clock
    always @(posedge core_clk) begin
        if (tick && !conv_down)
            pipe[0] <= conv_data;
    end
    genvar gi;
    generate
        for (gi = 1; gi < `SBUF_PIPE_LAT; gi = gi + 1) begin : g_pipe
            always @(posedge core_clk) begin
                if (tick && !conv_down)
                    pipe[gi] <= pipe[gi-1];
            end
        end
    endgenerate

    // RQ8 RQ16 write only while enabled and not stopped at full
    assign write_ok = tick & ~conv_down & ~bypass & (state == ST_CAPTURE) & wen_s &
        ~(full_flag & auto_stop);

    // RQ1 RQ3 sample store written on the sample clock
    always @(posedge core_clk) begin
        if (write_ok)
            mem[wr_ptr] <= conv_data;
    end

    // buffer state, pointers and flags
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            wr_count <= {CNT_W{1'b0}};
            rd_left <= {CNT_W{1'b0}};
            depth <= `SBUF_MIN_DEPTH;
            full_flag <= 1'b0;
            empty_flag <= 1'b1;
            overrun <= 1'b0;
        end else if (buf_reset) begin
            // RQ19 buffer reset ends reads, clears full and overrun, sets empty
            state <= ST_IDLE;
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            wr_count <= {CNT_W{1'b0}};
            rd_left <= {CNT_W{1'b0}};
            full_flag <= 1'b0;
            empty_flag <= 1'b1;
            overrun <= 1'b0;
        end else if (!full_down) begin
            case (state)
                ST_IDLE: begin
                    // RQ21 depth taken only while idle
                    depth <= sel_depth;
                    if (wen_rise && !bypass) begin
                        // RQ18 capture start clears empty
                        state <= ST_CAPTURE;
                        wr_ptr <= {PTR_W{1'b0}};
                        wr_count <= {CNT_W{1'b0}};
                        empty_flag <= 1'b0;
                        overrun <= 1'b0;
                    end else if (ren_rise && wr_count == depth) begin
                        // RQ17 read start clears full
                        state <= ST_READ;
                        rd_ptr <= wr_ptr;
                        rd_left <= depth;
                        wr_count <= {CNT_W{1'b0}};
                        full_flag <= 1'b0;
                    end
                end
                ST_CAPTURE: begin
                    if (!wen_s) begin
                        state <= ST_IDLE;
                    end else if (write_ok) begin
                        // RQ13 wrap at depth, full once filled
                        wr_ptr <= ptr_inc(wr_ptr, depth);
                        if (wr_count != depth)
                            wr_count <= wr_count + 1'b1;
                        if (wr_count >= depth - 1'b1)
                            full_flag <= 1'b1;
                        if (full_flag)
                            overrun <= 1'b1;
                    end
                end
                ST_READ: begin
                    if (wen_rise || (wen_s && !bypass)) begin
                        // RQ12 abort read, clear pointers, capture
                        state <= ST_CAPTURE;
                        wr_ptr <= {PTR_W{1'b0}};
                        rd_ptr <= {PTR_W{1'b0}};
                        wr_count <= {CNT_W{1'b0}};
                        rd_left <= {CNT_W{1'b0}};
                        full_flag <= 1'b0;
                        empty_flag <= 1'b0;
                        overrun <= 1'b0;
                    end else if (rclk_rise) begin
                        rd_ptr <= ptr_inc(rd_ptr, depth);
                        rd_left <= rd_left - 1'b1;
                        if (rd_left == {{PTR_W{1'b0}}, 1'b1}) begin
                            // RQ14 last word read sets empty
                            state <= ST_IDLE;
                            empty_flag <= 1'b1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // output word and strobe
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= {DATA_W{1'b1}};
            data_ready_strobe <= 1'b1;
        end else if (full_down) begin
            data_out <= {DATA_W{idle_level}};
            data_ready_strobe <= idle_level;
        end else if (bypass) begin
            if (tick && !conv_down) begin
                // RQ4 straight binary passes unchanged
                data_out <= pipe[`SBUF_PIPE_LAT-1];
                data_ready_strobe <= ~data_ready_strobe;
            end
        end else if (state == ST_READ && rclk_rise && !wen_s) begin
            // RQ22 strobe toggles with each word
            data_out <= mem[rd_ptr];
            data_ready_strobe <= ~data_ready_strobe;
        end else if (state != ST_READ) begin
            // RQ15 hold idle level while not reading
            data_out <= {DATA_W{idle_level}};
            data_ready_strobe <= idle_level;
        end
    end

    // apb slave, one wait state per access
    assign apb_access = psel & penable & ~pready;

    always @* begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            `SBUF_CTRL_OFF: begin
                next_prdata[`SBUF_CTRL_WIDTH-1:0] = ctrl;
            end
            `SBUF_CMD_OFF: begin
                next_prdata = 32'h0000_0000;
            end
            `SBUF_STATUS_OFF: begin
                next_prdata[`SBUF_ST_FULL] = full_flag;
                next_prdata[`SBUF_ST_EMPTY] = empty_flag;
                next_prdata[`SBUF_ST_READING] = (state == ST_READ);
                next_prdata[`SBUF_ST_OVERRUN] = overrun;
                next_prdata[`SBUF_ST_CAPTURING] = (state == ST_CAPTURE);
                next_prdata[`SBUF_ST_COUNT_LO+CNT_W-1:`SBUF_ST_COUNT_LO] = wr_count;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl <= `SBUF_CTRL_RESET;
            buf_reset <= 1'b0;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access & next_pslverr;
            buf_reset <= 1'b0;
            if (apb_access && !pwrite)
                prdata <= next_prdata;
            else if (apb_access)
                prdata <= 32'h0000_0000;
            if (apb_access && pwrite && paddr == `SBUF_CTRL_OFF)
                ctrl <= pwdata[`SBUF_CTRL_WIDTH-1:0];
            // RQ19 software buffer reset pulse
            if (apb_access && pwrite && paddr == `SBUF_CMD_OFF)
                buf_reset <= pwdata[`SBUF_CMD_BUF_RESET];
        end
    end
endmodule // sbuf_capture

// File: sbuf_reader.v.sv
// reader model: waits for a full buffer, then clocks words out
`timescale 1ns/100ps
module sbuf_reader (
    input wire core_clk, // block clock, paces the enable
    input wire go, // start one read frame
    input wire [10:0] n, // words to clock out
    input wire full_flag, // buffer full
    input wire capture_write_enable, // write enable on the pin
    input wire [7:0] data_out, // output word
    input wire data_ready_strobe, // word strobe
    output reg read_clk, // read clock, still outside frames
    output reg buffer_read_enable, // read enable
    output reg busy // frame in progress
);
    reg [7:0] words [0:1023];
    reg last;
    integer cnt;
    integer i;
    initial begin
        read_clk = 1'b0;
        buffer_read_enable = 1'b0;
        busy = 1'b0;
        cnt = 0;
        last = 1'b1;
    end
    always @(negedge core_clk) begin
        if (buffer_read_enable && data_ready_strobe !== last && cnt < n) begin
            words[cnt] = data_out;
            cnt = cnt + 1;
        end
        last = data_ready_strobe;
    end
    always @(posedge go) begin
        busy = 1'b1;
        cnt = 0;
        wait (full_flag === 1'b1 && capture_write_enable === 1'b0);
        @(posedge core_clk);
        buffer_read_enable <= 1'b1;
        #200;
        for (i = 0; i < n; i = i + 1) begin
            #62.5 read_clk = 1'b1;
            #62.5 read_clk = 1'b0;
        end
        #300;
        @(posedge core_clk);
        buffer_read_enable <= 1'b0;
        busy <= 1'b0;
    end
endmodule // sbuf_reader

// File: sbuf_capture_properties.sv
// port assertions of the sample capture buffer
`timescale 1ns/100ps
module sbuf_capture_properties (
    input wire core_clk, // block clock
    input wire resetn, // reset, active low
    input wire psel, // apb select
    input wire penable, // apb access
    input wire pwrite, // apb direction
    input wire [11:0] paddr, // apb address
    input wire [31:0] pwdata, // apb write data
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire capture_write_enable, // write enable pin
    input wire read_clk, // read clock pin
    input wire [7:0] data_out, // output word
    input wire data_ready_strobe, // word strobe
    input wire full_flag, // buffer full
    input wire empty_flag, // buffer read out
    input wire sample_clk_tick // sample clock pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    reg [8:0] ctrl_q;
    reg [3:0] rclk_age;
    reg [3:0] wen_cnt;
    reg rclk_q;
    // shadow control and pin ages, saturating so they never wrap
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= 9'h000;
            rclk_age <= 4'hF;
            wen_cnt <= 4'h0;
            rclk_q <= 1'b0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 12'h000)
                ctrl_q <= pwdata[8:0];
            rclk_q <= read_clk;
            rclk_age <= (read_clk && !rclk_q) ? 4'h0 : rclk_age + {3'h0, rclk_age != 4'hF};
            wen_cnt <= !capture_write_enable ? 4'h0 : wen_cnt + {3'h0, wen_cnt != 4'hF};
        end
    end
    property p_pready_pulse; pready |=> !pready; endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("access not answered next cycle");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_full_not_empty; full_flag |-> !empty_flag; endproperty
    a_full_not_empty: assert property (p_full_not_empty) else $error("full and empty together");
    property p_idle_level;
        empty_flag && $past(empty_flag) && !ctrl_q[0] && ctrl_q == $past(ctrl_q, 2)
        |-> data_out == {8{~ctrl_q[2]}} && data_ready_strobe == ~ctrl_q[2];
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("outputs off idle level");
    property p_full_on_tick; $rose(full_flag) |-> sample_clk_tick || $past(sample_clk_tick); endproperty
    a_full_on_tick: assert property (p_full_on_tick) else $error("full rose off a sample");
    property p_strobe_cause;
        $changed(data_ready_strobe) && !ctrl_q[0] && !empty_flag && !$past(empty_flag)
        && wen_cnt == 4'h0 |-> rclk_age < 4'h9;
    endproperty
    a_strobe_cause: assert property (p_strobe_cause) else $error("strobe moved without read clock");
    property p_down_still; ctrl_q[7] && $past(ctrl_q[7], 4) |-> !sample_clk_tick; endproperty
    a_down_still: assert property (p_down_still) else $error("sampling in power-down");
    property p_empty_fall; $fell(empty_flag) |-> wen_cnt >= 4'h2 && wen_cnt <= 4'h6; endproperty
    a_empty_fall: assert property (p_empty_fall) else $error("empty cleared without capture");
    property p_empty_rise; $rose(empty_flag) |-> wen_cnt == 4'h0; endproperty
    a_empty_rise: assert property (p_empty_rise) else $error("empty rose while writing");
    c_full: cover property ($rose(full_flag));
    c_empty: cover property ($rose(empty_flag));
    c_bypass: cover property (ctrl_q[0] && $changed(data_ready_strobe));
endmodule // sbuf_capture_properties
bind sbuf_capture sbuf_capture_properties i_props (.*);

// File: sbuf_capture_tb.sv
// self-checking bench for the sample capture buffer
`timescale 1ns/100ps
`include "sbuf_regs.vh"
module sbuf_capture_tb;
    reg core_clk, resetn, psel, penable, pwrite, capture_write_enable, go, err, s;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [7:0] conv_data, d8;
    reg [10:0] n;
    wire [31:0] prdata;
    wire [7:0] data_out;
    wire pready, pslverr, read_clk, buffer_read_enable, busy;
    wire data_ready_strobe, full_flag, empty_flag, sample_clk_tick;
    integer mismatches, samples_checked, i, j, k;
    sbuf_capture i_dut (.*);
    sbuf_reader i_rdr (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        conv_data <= conv_data + 8'h01;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1)
                @(posedge core_clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wait_idle;
        begin
            while (busy === 1'b1)
                @(posedge core_clk);
        end
    endtask
    task start_read(input [10:0] cnt, input integer w);
        begin
            n <= cnt;
            go <= 1'b1;
            @(posedge core_clk);
            go <= 1'b0;
            @(posedge core_clk);
            while (busy === 1'b1 && i_rdr.cnt < w)
                @(posedge core_clk);
        end
    endtask
    task capture(input [8:0] ctrl, input [10:0] depth);
        begin
            apb(1'b1, `SBUF_CTRL_OFF, {23'h000000, ctrl});
            capture_write_enable <= 1'b1;
            repeat (8) @(posedge core_clk);
            chk(empty_flag, 1'b0);
            while (full_flag !== 1'b1)
                @(posedge core_clk);
            // run on past full so a wrap or a halt shows
            repeat (512) @(posedge core_clk);
            apb(1'b0, `SBUF_STATUS_OFF, 32'h0);
            chk(rd[26:16], depth);
            chk(rd[1:0], 2'h1);
            chk(rd[`SBUF_ST_OVERRUN], !ctrl[1]);
            capture_write_enable <= 1'b0;
            repeat (8) @(posedge core_clk);
        end
    endtask
    task read_out(input [10:0] cnt, input [7:0] step, input idle);
        begin
            start_read(cnt, 2048);
            chk(i_rdr.cnt, cnt);
            for (i = 1; i < cnt; i = i + 1) begin
                d8 = i_rdr.words[i] - i_rdr.words[i-1];
                chk(d8, step);
            end
            chk({full_flag, empty_flag}, 2'h1);
            chk({data_ready_strobe, data_out}, {9{idle}});
            $display("read of %0d words done", cnt);
        end
    endtask
    task t_reset;
        begin
            chk({full_flag, empty_flag}, 2'h1);
            chk({data_ready_strobe, data_out}, 9'h1FF);
            apb(1'b0, `SBUF_CTRL_OFF, 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, 12'h0F0, 32'h5A);
            chk(err, 1'b1);
            $display("reset test done");
        end
    endtask
    task t_abort;
        begin
            capture(9'h01A, 11'h080);
            start_read(11'h080, 40);
            capture_write_enable <= 1'b1;
            repeat (10) @(posedge core_clk);
            apb(1'b0, `SBUF_STATUS_OFF, 32'h0);
            chk(rd[4:0], 5'h10);
            wait_idle;
            capture_write_enable <= 1'b0;
            repeat (8) @(posedge core_clk);
            start_read(11'h080, 40);
            apb(1'b1, `SBUF_CMD_OFF, 32'h1);
            apb(1'b0, `SBUF_STATUS_OFF, 32'h0);
            chk(rd[26:0], 27'h0000002);
            repeat (100) @(posedge core_clk);
            chk({data_ready_strobe, data_out}, 9'h1FF);
            wait_idle;
            $display("abort test done");
        end
    endtask
    task t_rates;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                // both power-downs, then converter power-down alone
                k = (i == 4) ? 32'h199 : 32'h119;
                apb(1'b1, `SBUF_CTRL_OFF, (i < 4) ? (32'h1 | (i << 3)) : k);
                repeat (16) @(posedge core_clk);
                k = 0;
                j = 0;
                s = data_ready_strobe;
                repeat (64) begin
                    @(posedge core_clk);
                    k = k + sample_clk_tick;
                    j = j + (data_ready_strobe !== s);
                    s = data_ready_strobe;
                    // ramp steps once a cycle, so six samples back plus this edge
                    d8 = conv_data - 8'h07;
                    if (i == 3)
                        chk(data_out, d8);
                end
                chk(k, (i < 4) ? (8 << i) : ((i == 5) ? 64 : 0));
                chk(j, (i < 4) ? (8 << i) : 0);
            end
            chk({data_ready_strobe, data_out}, 9'h1FF);
            apb(1'b1, `SBUF_CTRL_OFF, 32'h0);
            $display("rate test done");
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        // a few times the expected run length
        #400000;
        mismatches = mismatches + 1;
        summarize;
    end
    initial begin
        {resetn, psel, penable, pwrite, capture_write_enable, go} = 6'h00;
        {paddr, pwdata, conv_data, n} = 63'h0;
        mismatches = 0;
        samples_checked = 0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_reset;
        capture(9'h01A, 11'h080);
        read_out(11'h080, 8'h01, 1'b1);
        capture(9'h02C, 11'h100);
        read_out(11'h100, 8'h04, 1'b0);
        t_abort;
        t_rates;
        summarize;
    end
endmodule // sbuf_capture_tb
